// ==== hw/pmr_bank.sv ====
`timescale 1ns/1ps
// Overview of operation
// (RL1) Registers reached only by indexed management access
// (RL2) Decode indexes 0-6, 17, 18, 27, 29-31
// (RL3) Kept fields survive soft reset only
// (RL4) Control bit 15 soft resets, self-clears
// (RL5) Control bit 14 selects loopback, resets zero
// (RL6) Bit 13 forces 100M when negotiation off
// (RL7) Bit 12 enables negotiation, resets one
// (RL8) Bit 11 powers down; completion reported later
// (RL9) Control bit 9 restarts negotiation, self-clears
// (RL10) Bit 8 selects duplex unless negotiating
// (RL11) Control bit 7 enables collision test
// (RL12) Speed and duplex follow negotiation outcome
// (RL13) Status 15-11 report fixed abilities
// (RL14) Status 5 done, 3 and 0 read one
// (RL15) Status 4 remote fault latches high
// (RL16) Status 2 link latches low
// (RL17) Status 1 jabber latches high
// (RL18) Identifier registers read-only, fixed layout
// (RL19) Advertised pause field encoding, resets 00
// (RL20) Both pause advertised resolves to one
// (RL21) Ability bits writable reset one, selector 00001
// (RL22) Advertised remote fault writable, resets zero
// (RL23) Latches hold until read; reserved read zero; advertisement bit 12 reads back as written
module pmr_bank import pmr_pkg::*; #(
	parameter logic [ID_OUI_W-1:0] OUI_ID = 22'h2_1357, // Arbitrary
	parameter logic [ID_MODEL_W-1:0] MODEL_ID = 6'h2a, // Arbitrary
	parameter logic [ID_REV_W-1:0] REV_ID = 4'h5 // Arbitrary
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Indexed management access
	input wire logic mgmt_wr,
	input wire logic mgmt_rd,
	input wire logic [IDX_W-1:0] mgmt_index,
	input wire logic [DATA_W-1:0] mgmt_wdata,
	output logic [DATA_W-1:0] mgmt_rdata_q,
	output logic mgmt_ack_q,
	output logic mgmt_hit_q,
	// Line condition pins
	input wire logic link_up_pin,
	input wire logic remote_fault_pin,
	input wire logic jabber_pin,
	// Negotiation engine results
	input wire logic an_done,
	input wire logic an_speed_100,
	input wire logic an_full_duplex,
	input wire logic [1:0] partner_pause,
	// Operating mode
	output logic soft_reset_q,
	output logic an_restart_q,
	output logic loopback_q,
	output logic power_down_q,
	output logic col_test_q,
	output logic an_enable_q,
	output logic link_speed_100_q,
	output logic link_full_duplex_q,
	// Advertisement to the negotiation engine
	output logic adv_remote_fault_q,
	output logic [1:0] adv_pause_q,
	output logic [3:0] adv_ability_q,
	output logic pause_sym_q,
	output logic pause_asym_q
);

	// ************************************************************
	// Index decode
	// ************************************************************
	function automatic logic [2:0] ext_slot(input logic [IDX_W-1:0] idx);
		logic [2:0] s;
		s = SLOT_NONE;
		if (idx == IDX_MODE_CS) begin
			s = SLOT_MODE_CS;
		end else if (idx == IDX_SPECIAL) begin
			s = SLOT_SPECIAL;
		end else if (idx == IDX_SPEC_IND) begin
			s = SLOT_SPEC_IND;
		end else if (idx == IDX_IRQ_SRC) begin
			s = SLOT_IRQ_SRC;
		end else if (idx == IDX_IRQ_MASK) begin
			s = SLOT_IRQ_MASK;
		end else if (idx == IDX_PHY_SCS) begin
			s = SLOT_PHY_SCS;
		end
		return s;
	endfunction

	logic rst_all;
	logic wr_ctl;
	logic wr_adv;
	logic rd_sts;
	logic [2:0] slot;
	logic link_up;
	logic remote_fault;
	logic jabber;
	logic link_flag;
	logic rfault_flag;
	logic jabber_flag;
	logic an_done_d1_q;
	logic an_done_live;
	logic [DATA_W-1:0] rd_d;
	logic hit_d;
	logic [DATA_W-1:0] ext_q [EXT_SLOTS];

	// Soft reset acts one cycle after the write that asks for it
	assign rst_all = sys_rst | soft_reset_q; // RL3
	assign wr_ctl = mgmt_wr && (mgmt_index == IDX_CONTROL); // RL1
	assign wr_adv = mgmt_wr && (mgmt_index == IDX_ADVERT);
	assign rd_sts = mgmt_rd && (mgmt_index == IDX_STATUS); // RL23
	assign slot = ext_slot(mgmt_index); // RL2
	assign an_done_live = an_done & an_enable_q & ~power_down_q; // RL8

	// ************************************************************
	// Line condition sampling and latching flags
	// ************************************************************
	pmr_pin_sync #(
		.W(3)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_in({link_up_pin, remote_fault_pin, jabber_pin}),
		.level_q({link_up, remote_fault, jabber})
	);

	pmr_latch_flag #(
		.HIGH(1'b0)
	) u_link (
		.clk(clk),
		.rst(rst_all),
		.cond(link_up),
		.rd_clr(rd_sts),
		.flag_q(link_flag)
	); // RL16

	pmr_latch_flag #(
		.HIGH(1'b1)
	) u_rfault (
		.clk(clk),
		.rst(rst_all),
		.cond(remote_fault),
		.rd_clr(rd_sts),
		.flag_q(rfault_flag)
	); // RL15

	pmr_latch_flag #(
		.HIGH(1'b1)
	) u_jabber (
		.clk(clk),
		.rst(rst_all),
		.cond(jabber),
		.rd_clr(rd_sts),
		.flag_q(jabber_flag)
	); // RL17

	// ************************************************************
	// Basic control
	// ************************************************************
	// The pulse bits are held for one cycle only; they read back as zero once done
	always_ff @(posedge clk) begin
		if (rst_all) begin
			soft_reset_q <= 1'b0;
			an_restart_q <= 1'b0;
		end else begin
			soft_reset_q <= wr_ctl & mgmt_wdata[CTL_RESET]; // RL4
			an_restart_q <= wr_ctl & mgmt_wdata[CTL_AN_RESTART]; // RL9
		end
	end

	always_ff @(posedge clk) begin
		if (rst_all) begin
			loopback_q <= 1'b0; // RL5
			an_enable_q <= 1'b1; // RL7
			power_down_q <= 1'b0;
			col_test_q <= 1'b0; // RL11
		end else if (wr_ctl) begin
			loopback_q <= mgmt_wdata[CTL_LOOP]; // RL5
			an_enable_q <= mgmt_wdata[CTL_AN_EN]; // RL7
			power_down_q <= mgmt_wdata[CTL_PDOWN]; // RL8
			col_test_q <= mgmt_wdata[CTL_COL_TEST]; // RL11
		end
	end

	// Forced bits take the negotiated result once negotiation is done and not powered down
	logic ctl_speed_q;
	logic ctl_duplex_q;
	always_ff @(posedge clk) begin
		if (rst_all) begin
			ctl_speed_q <= SPEED_RST;
			ctl_duplex_q <= DUPLEX_RST;
		end else if (wr_ctl) begin
			ctl_speed_q <= mgmt_wdata[CTL_SPEED]; // RL6
			ctl_duplex_q <= mgmt_wdata[CTL_DUPLEX]; // RL10
		end else if (an_done_live) begin
			ctl_speed_q <= an_speed_100; // RL12
			ctl_duplex_q <= an_full_duplex; // RL12
		end
	end

	always_ff @(posedge clk) begin
		if (rst_all) begin
			link_speed_100_q <= SPEED_RST;
			link_full_duplex_q <= DUPLEX_RST;
		end else if (an_enable_q) begin
			link_speed_100_q <= an_done ? an_speed_100 : ctl_speed_q; // RL7
			link_full_duplex_q <= an_done ? an_full_duplex : ctl_duplex_q;
		end else begin
			link_speed_100_q <= ctl_speed_q; // RL6
			link_full_duplex_q <= ctl_duplex_q; // RL10
		end
	end

	// ************************************************************
	// Advertisement
	// ************************************************************
	logic adv_res12_q;
	always_ff @(posedge clk) begin
		if (rst_all) begin
			adv_remote_fault_q <= 1'b0; // RL22
			adv_res12_q <= 1'b0;
			adv_pause_q <= PAUSE_NONE; // RL19
			adv_ability_q <= ADV_ABIL_RST; // RL21
		end else if (wr_adv) begin
			adv_remote_fault_q <= mgmt_wdata[ADV_RFAULT]; // RL22
			adv_res12_q <= mgmt_wdata[ADV_RES12];
			adv_pause_q <= mgmt_wdata[ADV_PAUSE_HI:ADV_PAUSE_LO]; // RL19
			adv_ability_q <= mgmt_wdata[ADV_ABIL_HI:ADV_ABIL_LO]; // RL21
		end
	end

	// Both pause kinds advertised: symmetric wins if the partner has it
	logic both_adv;
	assign both_adv = (adv_pause_q == PAUSE_BOTH);
	always_ff @(posedge clk) begin
		if (rst_all) begin
			an_done_d1_q <= 1'b0;
			pause_sym_q <= 1'b0;
			pause_asym_q <= 1'b0;
		end else begin
			an_done_d1_q <= an_done_live;
			if (an_done_live && !an_done_d1_q) begin
				pause_sym_q <= adv_pause_q[PAUSE_SYM]
					& partner_pause[PAUSE_SYM]; // RL20
				pause_asym_q <= adv_pause_q[PAUSE_ASYM]
					& partner_pause[PAUSE_ASYM]
					& ~(both_adv & partner_pause[PAUSE_SYM]); // RL20
			end else if (!an_done_live) begin
				pause_sym_q <= 1'b0;
				pause_asym_q <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Upper index storage
	// ************************************************************
	// Only hardware reset clears the kept slot
	always_ff @(posedge clk) begin
		for (int i = 0; i < EXT_SLOTS; i++) begin
			if (sys_rst) begin
				ext_q[i] <= '0;
			end else if (soft_reset_q) begin
				if (i[2:0] != SLOT_SPECIAL) begin
					ext_q[i] <= '0; // RL3
				end
			end else if (mgmt_wr && slot == i[2:0]) begin
				ext_q[i] <= mgmt_wdata; // RL2
			end
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	always_comb begin
		rd_d = '0; // RL23
		hit_d = 1'b1;
		if (mgmt_index == IDX_CONTROL) begin
			rd_d[CTL_RESET] = soft_reset_q; // RL4
			rd_d[CTL_LOOP] = loopback_q;
			rd_d[CTL_SPEED] = ctl_speed_q;
			rd_d[CTL_AN_EN] = an_enable_q;
			rd_d[CTL_PDOWN] = power_down_q;
			rd_d[CTL_AN_RESTART] = an_restart_q; // RL9
			rd_d[CTL_DUPLEX] = ctl_duplex_q;
			rd_d[CTL_COL_TEST] = col_test_q;
		end else if (mgmt_index == IDX_STATUS) begin
			rd_d[STS_ABIL_HI:STS_ABIL_LO] = STS_ABILITIES; // RL13
			rd_d[STS_AN_DONE] = an_done_live; // RL14
			rd_d[STS_RFAULT] = rfault_flag; // RL15
			rd_d[STS_AN_ABLE] = 1'b1; // RL14
			rd_d[STS_LINK] = link_flag; // RL16
			rd_d[STS_JABBER] = jabber_flag; // RL17
			rd_d[STS_EXT] = 1'b1; // RL14
		end else if (mgmt_index == IDX_ID_HIGH) begin
			rd_d = OUI_ID[ID_OUI_W-1:ID_MODEL_W]; // RL18
		end else if (mgmt_index == IDX_ID_LOW) begin
			rd_d = {OUI_ID[ID_MODEL_W-1:0], MODEL_ID, REV_ID}; // RL18
		end else if (mgmt_index == IDX_ADVERT) begin
			rd_d[ADV_RFAULT] = adv_remote_fault_q;
			rd_d[ADV_RES12] = adv_res12_q;
			rd_d[ADV_PAUSE_HI:ADV_PAUSE_LO] = adv_pause_q;
			rd_d[ADV_ABIL_HI:ADV_ABIL_LO] = adv_ability_q;
			rd_d[ADV_SEL_HI:0] = ADV_SELECTOR; // RL21
		end else if (mgmt_index == IDX_PARTNER
			|| mgmt_index == IDX_EXPAND) begin
			rd_d = '0;
		end else if (slot != SLOT_NONE) begin
			rd_d = ext_q[slot]; // RL2
		end else begin
			hit_d = 1'b0;
		end
	end

	// One answer per access, one cycle after it is taken
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mgmt_rdata_q <= '0;
			mgmt_ack_q <= 1'b0;
			mgmt_hit_q <= 1'b0;
		end else begin
			mgmt_rdata_q <= mgmt_rd ? rd_d : '0; // RL1
			mgmt_ack_q <= mgmt_rd | mgmt_wr;
			mgmt_hit_q <= (mgmt_rd | mgmt_wr) & hit_d;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_soft_self_clear: assert property (@(posedge clk) disable iff (sys_rst)
		wr_ctl && mgmt_wdata[CTL_RESET] && !soft_reset_q
		|=> soft_reset_q ##1 !soft_reset_q) // RL4
		else $error("Soft reset bit did not clear itself");

	a_kept_field: assert property (@(posedge clk) disable iff (sys_rst)
		soft_reset_q |=> $stable(ext_q[SLOT_SPECIAL])) // RL3
		else $error("Kept field changed on soft reset");

	a_soft_defaults: assert property (@(posedge clk) disable iff (sys_rst)
		soft_reset_q |=> !loopback_q && an_enable_q && !col_test_q
		&& adv_pause_q == PAUSE_NONE && !adv_remote_fault_q) // RL5
		else $error("Control defaults not restored by soft reset");

	a_forced_mode: assert property (@(posedge clk) disable iff (rst_all)
		!an_enable_q |=> link_speed_100_q == $past(ctl_speed_q)
		&& link_full_duplex_q == $past(ctl_duplex_q)) // RL6
		else $error("Forced speed not applied");

	a_an_override: assert property (@(posedge clk) disable iff (rst_all)
		an_enable_q && an_done |=> ##0 (soft_reset_q
		|| link_full_duplex_q == $past(an_full_duplex))) // RL10
		else $error("Negotiated duplex not applied");

	a_restart_pulse: assert property (@(posedge clk) disable iff (rst_all)
		wr_ctl && mgmt_wdata[CTL_AN_RESTART] && !mgmt_wdata[CTL_RESET]
		|=> an_restart_q) // RL9
		else $error("Restart pulse missing");

	a_status_fixed: assert property (@(posedge clk) disable iff (sys_rst)
		rd_sts |=> mgmt_ack_q
		&& mgmt_rdata_q[STS_ABIL_HI:STS_ABIL_LO] == STS_ABILITIES
		&& mgmt_rdata_q[STS_AN_ABLE] && mgmt_rdata_q[STS_EXT]) // RL13
		else $error("Fixed status bits wrong");

	a_jabber_hold: assert property (@(posedge clk) disable iff (rst_all)
		jabber_flag && !rd_sts |=> jabber_flag) // RL17
		else $error("Jabber flag dropped before read");

	a_link_hold: assert property (@(posedge clk) disable iff (rst_all)
		!link_flag && !rd_sts |=> !link_flag) // RL16
		else $error("Link flag rose before read");

	a_pause_one: assert property (@(posedge clk) disable iff (sys_rst)
		!(pause_sym_q && pause_asym_q)) // RL20
		else $error("Both pause settings resolved");

	a_adv_selector: assert property (@(posedge clk) disable iff (sys_rst)
		mgmt_rd && mgmt_index == IDX_ADVERT
		|=> mgmt_rdata_q[ADV_SEL_HI:0] == ADV_SELECTOR) // RL21
		else $error("Selector field wrong");

	c_soft_reset: cover property (@(posedge clk) disable iff (sys_rst)
		wr_ctl && mgmt_wdata[CTL_RESET] ##2 !soft_reset_q);

	c_pause_both: cover property (@(posedge clk) disable iff (sys_rst)
		both_adv && an_done_live ##1 pause_sym_q);

	c_link_relatch: cover property (@(posedge clk) disable iff (sys_rst)
		!link_flag && link_up && rd_sts ##1 link_flag);

endmodule // pmr_bank

// ==== hw/pmr_pkg.sv ====
package pmr_pkg;

	// ************************************************************
	// Index map and widths
	// ************************************************************
	localparam int IDX_W = 5;
	localparam int DATA_W = 16;
	localparam logic [4:0] IDX_CONTROL = 5'h00;
	localparam logic [4:0] IDX_STATUS = 5'h01;
	localparam logic [4:0] IDX_ID_HIGH = 5'h02;
	localparam logic [4:0] IDX_ID_LOW = 5'h03;
	localparam logic [4:0] IDX_ADVERT = 5'h04;
	localparam logic [4:0] IDX_PARTNER = 5'h05;
	localparam logic [4:0] IDX_EXPAND = 5'h06;
	localparam logic [4:0] IDX_MODE_CS = 5'h11;
	localparam logic [4:0] IDX_SPECIAL = 5'h12;
	localparam logic [4:0] IDX_SPEC_IND = 5'h1b;
	localparam logic [4:0] IDX_IRQ_SRC = 5'h1d;
	localparam logic [4:0] IDX_IRQ_MASK = 5'h1e;
	localparam logic [4:0] IDX_PHY_SCS = 5'h1f;

	// Plain storage slots for the upper indexes
	localparam int EXT_SLOTS = 6;
	localparam logic [2:0] SLOT_MODE_CS = 3'h0;
	localparam logic [2:0] SLOT_SPECIAL = 3'h1;
	localparam logic [2:0] SLOT_SPEC_IND = 3'h2;
	localparam logic [2:0] SLOT_IRQ_SRC = 3'h3;
	localparam logic [2:0] SLOT_IRQ_MASK = 3'h4;
	localparam logic [2:0] SLOT_PHY_SCS = 3'h5;
	localparam logic [2:0] SLOT_NONE = 3'h7;

	// ************************************************************
	// Basic control fields
	// ************************************************************
	localparam int CTL_RESET = 15;
	localparam int CTL_LOOP = 14;
	localparam int CTL_SPEED = 13;
	localparam int CTL_AN_EN = 12;
	localparam int CTL_PDOWN = 11;
	localparam int CTL_AN_RESTART = 9;
	localparam int CTL_DUPLEX = 8;
	localparam int CTL_COL_TEST = 7;
	localparam logic SPEED_RST = 1'h1;
	localparam logic DUPLEX_RST = 1'h1;

	// ************************************************************
	// Basic status fields
	// ************************************************************
	localparam int STS_ABIL_HI = 15;
	localparam int STS_ABIL_LO = 11;
	localparam int STS_AN_DONE = 5;
	localparam int STS_RFAULT = 4;
	localparam int STS_AN_ABLE = 3;
	localparam int STS_LINK = 2;
	localparam int STS_JABBER = 1;
	localparam int STS_EXT = 0;
	localparam logic [4:0] STS_ABILITIES = 5'h0f;

	// ************************************************************
	// Identifier and advertisement fields
	// ************************************************************
	localparam int ID_OUI_W = 22;
	localparam int ID_MODEL_W = 6;
	localparam int ID_REV_W = 4;
	localparam int ADV_RFAULT = 13;
	localparam int ADV_RES12 = 12;
	localparam int ADV_PAUSE_HI = 11;
	localparam int ADV_PAUSE_LO = 10;
	localparam int ADV_ABIL_HI = 8;
	localparam int ADV_ABIL_LO = 5;
	localparam int ADV_SEL_HI = 4;
	localparam logic [4:0] ADV_SELECTOR = 5'h01;
	localparam logic [3:0] ADV_ABIL_RST = 4'hf;
	localparam logic [1:0] PAUSE_NONE = 2'h0;
	localparam logic [1:0] PAUSE_BOTH = 2'h3;
	localparam int PAUSE_SYM = 0;
	localparam int PAUSE_ASYM = 1;

endpackage

// ==== hw/pmr_pin_sync.sv ====
`timescale 1ns/1ps
module pmr_pin_sync import pmr_pkg::*; #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Pins in, settled levels out
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level_q
);

	if (W < 1) begin : g_chk
		$error("pmr_pin_sync needs W of at least one");
	end

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A change is taken only once the last two stages agree
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			level_q <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					level_q[i] <= s3_q[i];
				end
			end
		end
	end

endmodule // pmr_pin_sync

// ==== hw/pmr_latch_flag.sv ====
`timescale 1ns/1ps
module pmr_latch_flag import pmr_pkg::*; #(
	parameter bit HIGH = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Live condition and read of the holding register
	input wire logic cond,
	input wire logic rd_clr,
	output logic flag_q
);

	// The read returns the flag to the live condition, so an event
	// in the read cycle itself is still seen afterwards.
	always_ff @(posedge clk) begin
		if (rst) begin
			flag_q <= 1'b0;
		end else if (rd_clr) begin
			flag_q <= cond;
		end else if (HIGH) begin
			flag_q <= flag_q | cond;
		end else begin
			flag_q <= flag_q & cond;
		end
	end

endmodule // pmr_latch_flag

// ==== testbench/pmr_mac_model.sv ====
`timescale 1ns/1ps
module pmr_mac_model import pmr_pkg::*; (
	// Clock
	input wire logic clk,
	// Requests toward the bank
	output logic mgmt_wr,
	output logic mgmt_rd,
	output logic [IDX_W-1:0] mgmt_index,
	output logic [DATA_W-1:0] mgmt_wdata,
	// Answers from the bank
	input wire logic [DATA_W-1:0] mgmt_rdata_q,
	input wire logic mgmt_ack_q,
	input wire logic mgmt_hit_q
);
	logic [DATA_W-1:0] rdata;
	logic ack;
	logic hit;

	initial begin
		mgmt_wr = 1'b0;
		mgmt_rd = 1'b0;
		mgmt_index = 5'h00;
		mgmt_wdata = 16'h0000;
	end

	// ************************************************************
	// One indexed access, request held for its taking edge
	// ************************************************************
	task access(input logic wr, input logic [IDX_W-1:0] idx,
		input logic [DATA_W-1:0] d);
		@(posedge clk);
		#1;
		mgmt_wr = wr;
		mgmt_rd = !wr;
		mgmt_index = idx;
		mgmt_wdata = d;
		@(posedge clk);
		#1;
		ack = mgmt_ack_q;
		hit = mgmt_hit_q;
		rdata = mgmt_rdata_q;
		mgmt_wr = 1'b0;
		mgmt_rd = 1'b0;
		// Idle lines show the inverse so a stale value cannot pass
		mgmt_index = ~idx;
		mgmt_wdata = ~d;
	endtask
endmodule // pmr_mac_model

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench import pmr_pkg::*;;
	// Arbitrary identifier values
	localparam logic [ID_OUI_W-1:0] OUI = 22'h1_2345;
	localparam logic [ID_MODEL_W-1:0] MDL = 6'h13;
	localparam logic [ID_REV_W-1:0] REV = 4'h9;
	logic clk, sys_rst, mgmt_wr, mgmt_rd, mgmt_ack_q, mgmt_hit_q;
	logic [4:0] mgmt_index;
	logic [15:0] mgmt_wdata, mgmt_rdata_q;
	logic link_up_pin, remote_fault_pin, jabber_pin;
	logic an_done, an_speed_100, an_full_duplex;
	logic [1:0] partner_pause, adv_pause_q;
	logic soft_reset_q, an_restart_q, loopback_q, power_down_q;
	logic col_test_q, an_enable_q, link_speed_100_q, link_full_duplex_q;
	logic adv_remote_fault_q, pause_sym_q, pause_asym_q;
	logic [3:0] adv_ability_q;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;

	pmr_bank #(.OUI_ID(OUI), .MODEL_ID(MDL), .REV_ID(REV)) uut (
		.clk(clk), .sys_rst(sys_rst), .mgmt_wr(mgmt_wr),
		.mgmt_rd(mgmt_rd), .mgmt_index(mgmt_index),
		.mgmt_wdata(mgmt_wdata), .mgmt_rdata_q(mgmt_rdata_q),
		.mgmt_ack_q(mgmt_ack_q), .mgmt_hit_q(mgmt_hit_q),
		.link_up_pin(link_up_pin), .remote_fault_pin(remote_fault_pin),
		.jabber_pin(jabber_pin), .an_done(an_done),
		.an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex),
		.partner_pause(partner_pause), .soft_reset_q(soft_reset_q),
		.an_restart_q(an_restart_q), .loopback_q(loopback_q),
		.power_down_q(power_down_q), .col_test_q(col_test_q),
		.an_enable_q(an_enable_q), .link_speed_100_q(link_speed_100_q),
		.link_full_duplex_q(link_full_duplex_q),
		.adv_remote_fault_q(adv_remote_fault_q),
		.adv_pause_q(adv_pause_q), .adv_ability_q(adv_ability_q),
		.pause_sym_q(pause_sym_q), .pause_asym_q(pause_asym_q));

	pmr_mac_model mac (
		.clk(clk), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
		.mgmt_index(mgmt_index), .mgmt_wdata(mgmt_wdata),
		.mgmt_rdata_q(mgmt_rdata_q), .mgmt_ack_q(mgmt_ack_q),
		.mgmt_hit_q(mgmt_hit_q));

	// ************************************************************
	// Helpers
	// ************************************************************
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task wr(input logic [4:0] i, input logic [15:0] d);
		mac.access(1'b1, i, d);
	endtask

	task rd(input logic [4:0] i, input logic [15:0] e);
		mac.access(1'b0, i, 16'h0000);
		chk(16'(mac.ack), 16'h0001, "ack");
		chk(mac.rdata, e, "read data");
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task t_reset_values;
		chk(16'({loopback_q, power_down_q, col_test_q, an_enable_q}),
			16'h0001, "mode levels");
		rd(IDX_CONTROL, 16'h3100);
		rd(IDX_STATUS, 16'h7809);
		rd(IDX_ADVERT, 16'h01e1);
		rd(IDX_ID_HIGH, OUI[21:6]);
		wr(IDX_ID_LOW, 16'h0000);
		rd(IDX_ID_LOW, {OUI[5:0], MDL, REV});
	endtask

	task t_control;
		wr(IDX_CONTROL, 16'h7fff);
		chk(16'(an_restart_q), 16'h0001, "restart");
		chk(16'({loopback_q, power_down_q, col_test_q}), 16'h0007,
			"modes on");
		rd(IDX_CONTROL, 16'h7980);
		wr(IDX_CONTROL, 16'h0000);
		// The mode outputs follow the stored bits one cycle later
		cyc(1);
		chk(16'({an_enable_q, link_speed_100_q, link_full_duplex_q}),
			16'h0000, "forced 10 half");
	endtask

	task t_negotiate;
		an_speed_100 = 1'b0;
		an_full_duplex = 1'b0;
		an_done = 1'b1;
		wr(IDX_CONTROL, 16'h2100);
		cyc(1);
		chk(16'({link_speed_100_q, link_full_duplex_q}), 16'h0003,
			"forced 100 full");
		wr(IDX_CONTROL, 16'h3100);
		cyc(2);
		chk(16'({link_speed_100_q, link_full_duplex_q}), 16'h0000,
			"negotiated");
		rd(IDX_CONTROL, 16'h1000);
		rd(IDX_STATUS, 16'h7829);
		wr(IDX_CONTROL, 16'h1800);
		rd(IDX_STATUS, 16'h7809);
		wr(IDX_CONTROL, 16'h1000);
		rd(IDX_STATUS, 16'h7829);
	endtask

	task t_pause;
		an_done = 1'b0;
		partner_pause = 2'b11;
		wr(IDX_ADVERT, 16'h0de1);
		an_done = 1'b1;
		cyc(2);
		chk(16'({pause_sym_q, pause_asym_q}), 16'h0002, "sym");
		an_done = 1'b0;
		partner_pause = 2'b10;
		cyc(2);
		chk(16'({pause_sym_q, pause_asym_q}), 16'h0000, "none");
		an_done = 1'b1;
		cyc(2);
		chk(16'({pause_sym_q, pause_asym_q}), 16'h0001, "asym");
		for (int k = 0; k < 4; k++) begin
			wr(IDX_ADVERT, {4'h0, 2'(k), 10'h1e1});
			rd(IDX_ADVERT, {4'h0, 2'(k), 10'h1e1});
			chk(16'(adv_pause_q), 16'(k), "pause out");
		end
	endtask

	task t_advert;
		wr(IDX_ADVERT, 16'hffff);
		rd(IDX_ADVERT, 16'h3de1);
		chk(16'({adv_remote_fault_q, adv_ability_q}), 16'h001f,
			"adv set");
		wr(IDX_ADVERT, 16'h0000);
		rd(IDX_ADVERT, 16'h0001);
		chk(16'({adv_remote_fault_q, adv_ability_q}), 16'h0000,
			"adv clear");
	endtask

	task t_latches;
		an_done = 1'b0;
		link_up_pin = 1'b1;
		cyc(8);
		rd(IDX_STATUS, 16'h7809);
		rd(IDX_STATUS, 16'h780d);
		link_up_pin = 1'b0;
		cyc(8);
		link_up_pin = 1'b1;
		cyc(8);
		rd(IDX_STATUS, 16'h7809);
		jabber_pin = 1'b1;
		cyc(8);
		jabber_pin = 1'b0;
		cyc(8);
		rd(IDX_STATUS, 16'h780f);
		rd(IDX_STATUS, 16'h780d);
		remote_fault_pin = 1'b1;
		cyc(8);
		remote_fault_pin = 1'b0;
		cyc(8);
		wr(IDX_STATUS, 16'h0000);
		rd(IDX_STATUS, 16'h781d);
		rd(IDX_STATUS, 16'h780d);
	endtask

	task t_soft_reset;
		wr(IDX_SPECIAL, 16'h1234);
		wr(IDX_CONTROL, 16'h4000);
		wr(IDX_CONTROL, 16'h8000);
		chk(16'(soft_reset_q), 16'h0001, "soft reset");
		rd(IDX_CONTROL, 16'h3100);
		chk(16'(loopback_q), 16'h0000, "loop cleared");
		rd(IDX_SPECIAL, 16'h1234);
		for (int i = 0; i < 32; i++) begin
			mac.access(1'b0, 5'(i), 16'h0000);
			chk(16'(mac.hit), 16'(i <= 6 || i == 17 || i == 18 ||
				i == 27 || i >= 29), "decode");
		end
		wr(5'h08, 16'hffff);
		rd(5'h08, 16'h0000);
	endtask

	// ************************************************************
	// Clock, watchdog and main sequence
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			$display("mismatch at %0t: run did not finish", $time);
			print_verdict;
		end
	end

	initial begin
		sys_rst = 1'b1;
		link_up_pin = 1'b0;
		remote_fault_pin = 1'b0;
		jabber_pin = 1'b0;
		an_done = 1'b0;
		an_speed_100 = 1'b0;
		an_full_duplex = 1'b0;
		partner_pause = 2'b00;
		repeat (6) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		t_reset_values();
		t_control();
		t_negotiate();
		t_pause();
		t_advert();
		t_latches();
		t_soft_reset();
		print_verdict;
	end
endmodule // testbench
